// ---- hw/bcdcal_top.sv ----
// bcd calendar clock with programmable alarm, register port and wake-up
//
// Summary of operation
// (R1) count advances only while run enable set
// (R2) software stops clock before editing time fields
// (R3) unmask low suppresses alarm interrupt
// (R4) unmasked match sets clock alarm flag
// (R5) alarm enable gates alarm detection
// (R6) on or sleep: match drives interrupt low
// (R7) off state: match issues wake-up event
// (R8) all time values held as bcd digits
// (R9) years 2000-2099, leap every fourth year
// (R10) count reads return live counter value
// (R11) seconds 00-59, carry into minutes
// (R12) minutes 00-59, carry into hours
// (R13) hours tens 0-2, units 0-9
// (R14) software never writes out-of-range digits
// (R15) match on compare-enabled fields only
// (R16) alarm bit latched, cleared by alarm control write
// (R17) weekday counts 1 to 7, wraps
// (R18) date rolls by month length into month
// (R19) hours 00-23, carry into day counters
// (R20) month 01-12 carries year, year wraps
`timescale 1ns/10ps
`default_nettype none
`include "bcdcal_map.svh"
module bcdcal_top #(
	parameter int TICK_CYCLES = `BCDCAL_TICK_CYCLES
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	input  wire bcdcal_pkg::bcdcal_pwr_t pwr_state,
	input  wire logic                 irq_clear,
	output logic                      irq_out_n,
	output logic                      alarm_int_set,
	output logic                      wake_req
);
	import bcdcal_pkg::*;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// bcd step with wrap: returns {carry, next value}
	function automatic logic [8:0] bcdcal_inc(
		input logic [7:0] val,
		input logic [7:0] top,
		input logic [7:0] first
	);
		if (val == top) begin
			bcdcal_inc = {1'b1, first};
		end else if (val[3:0] == 4'h9) begin
			bcdcal_inc = {1'b0, val[7:4] + 4'h1, 4'h0};
		end else begin
			bcdcal_inc = {1'b0, val[7:4], val[3:0] + 4'h1};
		end
	endfunction : bcdcal_inc

	// a bcd year is a multiple of four when an even tens digit meets
	// units 0/4/8, or an odd tens digit meets units 2/6
	function automatic logic bcdcal_leap(input logic [7:0] year);
		logic u_even4;
		logic u_odd4;
		u_even4 = (year[3:0] == 4'h0) | (year[3:0] == 4'h4) |
			(year[3:0] == 4'h8);
		u_odd4 = (year[3:0] == 4'h2) | (year[3:0] == 4'h6);
		bcdcal_leap = year[4] ? u_odd4 : u_even4;
	endfunction : bcdcal_leap

	function automatic logic [7:0] bcdcal_last_day(
		input logic [4:0] mon,
		input logic [7:0] year
	);
		unique case (mon)
			5'h02: begin
				bcdcal_last_day = bcdcal_leap(year) ? 8'h29 : 8'h28;
			end
			5'h04, 5'h06, 5'h09, 5'h11: begin
				bcdcal_last_day = 8'h30;
			end
			default: begin
				bcdcal_last_day = 8'h31;
			end
		endcase
	endfunction : bcdcal_last_day

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	bcdcal_cmp_if cmp_bus ();

	logic [27:0]  tick_cnt_r;
	logic [27:0]  tick_cnt_nxt;
	logic         tick;
	logic [2:0]   ctrl_r;
	logic [2:0]   ctrl_nxt;
	bcdcal_time_t cnt_r;
	bcdcal_time_t cnt_nxt;
	bcdcal_time_t alm_r;
	bcdcal_time_t alm_nxt;
	logic [6:0]   cmp_en_r;
	logic [6:0]   cmp_en_nxt;
	logic         occurred_r;
	logic         occurred_nxt;
	logic         match_d_r;
	logic         match_d_nxt;
	logic         irq_pend_r;
	logic         irq_pend_nxt;
	logic         int_set_r;
	logic         int_set_nxt;
	logic         wake_r;
	logic         wake_nxt;
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	logic [8:0]   s_inc;
	logic [8:0]   m_inc;
	logic [8:0]   h_inc;
	logic [8:0]   d_inc;
	logic [8:0]   mo_inc;
	logic [8:0]   y_inc;
	logic         run_en;
	logic         fire;
	logic         awake;

	assign run_en = ctrl_r[`BCDCAL_CTRL_RUN];

	// ----------------------------------------------------------------
	// one-second prescaler
	// ----------------------------------------------------------------
	// held at zero while stopped, so a restart gives a full first second
	// (R1) run enable gates time
	assign tick = run_en & (tick_cnt_r == 28'(TICK_CYCLES - 1));

	always_comb begin
		tick_cnt_nxt = tick_cnt_r + 28'h0000001;
		if (!run_en || tick) begin
			tick_cnt_nxt = 28'h0000000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_cnt_r <= 28'h0000000;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// calendar counter and register writes
	// ----------------------------------------------------------------
	// (R8) bcd digit steps
	assign s_inc = bcdcal_inc({1'b0, cnt_r.sec}, `BCDCAL_TOP_SEC,
		`BCDCAL_FIRST_ZERO);
	assign m_inc = bcdcal_inc({1'b0, cnt_r.min}, `BCDCAL_TOP_MIN,
		`BCDCAL_FIRST_ZERO);
	// (R13) hour digit ranges
	assign h_inc = bcdcal_inc({2'b00, cnt_r.hr}, `BCDCAL_TOP_HR,
		`BCDCAL_FIRST_ZERO);
	// (R18) month length rollover
	assign d_inc = bcdcal_inc({2'b00, cnt_r.date},
		bcdcal_last_day(cnt_r.mon, cnt_r.year), `BCDCAL_FIRST_ONE);
	assign mo_inc = bcdcal_inc({3'b000, cnt_r.mon}, `BCDCAL_TOP_MON,
		`BCDCAL_FIRST_ONE);
	assign y_inc = bcdcal_inc(cnt_r.year, `BCDCAL_TOP_YEAR,
		`BCDCAL_FIRST_ZERO);

	always_comb begin
		cnt_nxt = cnt_r;
		alm_nxt = alm_r;
		ctrl_nxt = ctrl_r;
		cmp_en_nxt = cmp_en_r;
		if (tick) begin
			// (R11) seconds wrap carry
			cnt_nxt.sec = s_inc[6:0];
			if (s_inc[8]) begin
				// (R12) minutes wrap carry
				cnt_nxt.min = m_inc[6:0];
				if (m_inc[8]) begin
					// (R19) 24-hour wrap
					cnt_nxt.hr = h_inc[5:0];
					if (h_inc[8]) begin
						// (R17) weekday 1..7
						if (cnt_r.dow == `BCDCAL_DOW_LAST) begin
							cnt_nxt.dow = `BCDCAL_DOW_FIRST;
						end else begin
							cnt_nxt.dow = cnt_r.dow + 3'h1;
						end
						cnt_nxt.date = d_inc[5:0];
						if (d_inc[8]) begin
							// (R20) month and year wrap
							cnt_nxt.mon = mo_inc[4:0];
							if (mo_inc[8]) begin
								// (R9) century 2000-2099
								cnt_nxt.year = y_inc[7:0];
							end
						end
					end
				end
			end
		end
		// a write replaces whatever the tick produced for that field
		if (reg_wr) begin
			unique case (reg_addr)
				`BCDCAL_OFS_CTRL:    ctrl_nxt = reg_wdata[2:0];
				`BCDCAL_OFS_SEC:     cnt_nxt.sec = reg_wdata[6:0];
				`BCDCAL_OFS_MIN:     cnt_nxt.min = reg_wdata[6:0];
				`BCDCAL_OFS_HR:      cnt_nxt.hr = reg_wdata[5:0];
				`BCDCAL_OFS_DOW:     cnt_nxt.dow = reg_wdata[2:0];
				`BCDCAL_OFS_DATE:    cnt_nxt.date = reg_wdata[5:0];
				`BCDCAL_OFS_MON:     cnt_nxt.mon = reg_wdata[4:0];
				`BCDCAL_OFS_YEAR:    cnt_nxt.year = reg_wdata;
				`BCDCAL_OFS_AL_SEC:  alm_nxt.sec = reg_wdata[6:0];
				`BCDCAL_OFS_AL_MIN:  alm_nxt.min = reg_wdata[6:0];
				`BCDCAL_OFS_AL_HR:   alm_nxt.hr = reg_wdata[5:0];
				`BCDCAL_OFS_AL_DOW:  alm_nxt.dow = reg_wdata[2:0];
				`BCDCAL_OFS_AL_DATE: alm_nxt.date = reg_wdata[5:0];
				`BCDCAL_OFS_AL_MON:  alm_nxt.mon = reg_wdata[4:0];
				`BCDCAL_OFS_AL_YEAR: alm_nxt.year = reg_wdata;
				`BCDCAL_OFS_AL_CTRL: cmp_en_nxt = reg_wdata[6:0];
				// spare and unmapped offsets take no write
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= '0;
			alm_r <= '0;
			ctrl_r <= 3'h0;
			cmp_en_r <= 7'h00;
		end else begin
			cnt_r <= cnt_nxt;
			alm_r <= alm_nxt;
			ctrl_r <= ctrl_nxt;
			cmp_en_r <= cmp_en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// alarm comparator
	// ----------------------------------------------------------------
	assign cmp_bus.count = cnt_r;
	assign cmp_bus.alarm = alm_r;
	assign cmp_bus.cmp_en = cmp_en_r;

	bcdcal_alarm bcdcal_alarm_i (
		.cmp (cmp_bus.cmp)
	);

	// ----------------------------------------------------------------
	// alarm events
	// ----------------------------------------------------------------
	// only the first cycle of a match fires, else a one-second match
	// would re-arm the interrupt every cycle after it is cleared
	// (R5) alarm enable gate
	assign fire = ctrl_r[`BCDCAL_CTRL_AL_EN] & cmp_bus.match & ~match_d_r;

	always_comb begin
		unique case (pwr_state)
			BCDCAL_PWR_ON, BCDCAL_PWR_SLEEP: begin
				awake = 1'b1;
			end
			default: begin
				awake = 1'b0;
			end
		endcase
	end

	always_comb begin
		match_d_nxt = cmp_bus.match;
		// (R16) latched, write clears
		occurred_nxt = occurred_r;
		if (reg_wr && reg_addr == `BCDCAL_OFS_AL_CTRL) begin
			occurred_nxt = 1'b0;
		end
		if (fire) begin
			occurred_nxt = 1'b1;
		end
		// (R4) flag set pulse
		// (R3) unmask gates interrupt
		int_set_nxt = fire & ctrl_r[`BCDCAL_CTRL_UNMASK];
		// (R6) interrupt pin pending
		irq_pend_nxt = irq_pend_r;
		if (irq_clear) begin
			irq_pend_nxt = 1'b0;
		end
		if (fire && ctrl_r[`BCDCAL_CTRL_UNMASK] && awake) begin
			irq_pend_nxt = 1'b1;
		end
		// (R7) wake-up from off
		wake_nxt = fire & ~awake;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			match_d_r <= 1'b0;
			occurred_r <= 1'b0;
			int_set_r <= 1'b0;
			irq_pend_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			match_d_r <= match_d_nxt;
			occurred_r <= occurred_nxt;
			int_set_r <= int_set_nxt;
			irq_pend_r <= irq_pend_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign irq_out_n = ~irq_pend_r;
	assign alarm_int_set = int_set_r;
	assign wake_req = wake_r;

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			// (R10) live counter read
			unique case (reg_addr)
				`BCDCAL_OFS_CTRL:    rdata_nxt = {5'h00, ctrl_r};
				`BCDCAL_OFS_SEC:     rdata_nxt = {1'b0, cnt_r.sec};
				`BCDCAL_OFS_MIN:     rdata_nxt = {1'b0, cnt_r.min};
				`BCDCAL_OFS_HR:      rdata_nxt = {2'b00, cnt_r.hr};
				`BCDCAL_OFS_DOW:     rdata_nxt = {5'h00, cnt_r.dow};
				`BCDCAL_OFS_DATE:    rdata_nxt = {2'b00, cnt_r.date};
				`BCDCAL_OFS_MON:     rdata_nxt = {3'h0, cnt_r.mon};
				`BCDCAL_OFS_YEAR:    rdata_nxt = cnt_r.year;
				`BCDCAL_OFS_AL_SEC:  rdata_nxt = {1'b0, alm_r.sec};
				`BCDCAL_OFS_AL_MIN:  rdata_nxt = {1'b0, alm_r.min};
				`BCDCAL_OFS_AL_HR:   rdata_nxt = {2'b00, alm_r.hr};
				`BCDCAL_OFS_AL_DOW:  rdata_nxt = {5'h00, alm_r.dow};
				`BCDCAL_OFS_AL_DATE: rdata_nxt = {2'b00, alm_r.date};
				`BCDCAL_OFS_AL_MON:  rdata_nxt = {3'h0, alm_r.mon};
				`BCDCAL_OFS_AL_YEAR: rdata_nxt = alm_r.year;
				`BCDCAL_OFS_AL_CTRL: rdata_nxt = {occurred_r, cmp_en_r};
				default:             rdata_nxt = `BCDCAL_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= `BCDCAL_RST_BYTE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule : bcdcal_top
`default_nettype wire

// ---- inc/bcdcal_map.svh ----
// register offsets, field positions, reset values and timing of the calendar
`ifndef BCDCAL_MAP_SVH
`define BCDCAL_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BCDCAL_OFS_CTRL       8'h3a
`define BCDCAL_OFS_SEC        8'h3b
`define BCDCAL_OFS_MIN        8'h3c
`define BCDCAL_OFS_HR         8'h3d
`define BCDCAL_OFS_DOW        8'h3e
`define BCDCAL_OFS_DATE       8'h3f
`define BCDCAL_OFS_MON        8'h40
`define BCDCAL_OFS_YEAR       8'h41
`define BCDCAL_OFS_AL_SEC     8'h42
`define BCDCAL_OFS_AL_MIN     8'h43
`define BCDCAL_OFS_AL_HR      8'h44
`define BCDCAL_OFS_AL_DOW     8'h45
`define BCDCAL_OFS_AL_DATE    8'h46
`define BCDCAL_OFS_AL_MON     8'h47
`define BCDCAL_OFS_AL_YEAR    8'h48
`define BCDCAL_OFS_AL_CTRL    8'h49
`define BCDCAL_OFS_SPARE_A    8'h4a
`define BCDCAL_OFS_SPARE_B    8'h4b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BCDCAL_CTRL_RUN       0
`define BCDCAL_CTRL_UNMASK    1
`define BCDCAL_CTRL_AL_EN     2
`define BCDCAL_ALC_OCCURRED   7

// ----------------------------------------------------------------
// reset values and counting limits (bcd)
// ----------------------------------------------------------------
`define BCDCAL_RST_BYTE       8'h00
`define BCDCAL_TOP_SEC        8'h59
`define BCDCAL_TOP_MIN        8'h59
`define BCDCAL_TOP_HR         8'h23
`define BCDCAL_TOP_MON        8'h12
`define BCDCAL_TOP_YEAR       8'h99
`define BCDCAL_FIRST_ZERO     8'h00
`define BCDCAL_FIRST_ONE      8'h01
`define BCDCAL_DOW_FIRST      3'h1
`define BCDCAL_DOW_LAST       3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BCDCAL_TICK_MS        1000
`define BCDCAL_CLK_KHZ        250000
`define BCDCAL_TICK_CYCLES    (`BCDCAL_TICK_MS * `BCDCAL_CLK_KHZ)

`endif

// ---- inc/bcdcal_pkg.sv ----
// types shared by the calendar clock modules
`default_nettype none
package bcdcal_pkg;

	typedef enum logic [1:0] {
		BCDCAL_PWR_ON,
		BCDCAL_PWR_SLEEP,
		BCDCAL_PWR_OFF
	} bcdcal_pwr_t;

	typedef struct packed {
		logic [7:0] year;
		logic [4:0] mon;
		logic [5:0] date;
		logic [2:0] dow;
		logic [5:0] hr;
		logic [6:0] min;
		logic [6:0] sec;
	} bcdcal_time_t;

endpackage : bcdcal_pkg
`default_nettype wire

// ---- inc/bcdcal_cmp_if.sv ----
// carrier between the calendar registers and the alarm comparator
`timescale 1ns/10ps
`default_nettype none
interface bcdcal_cmp_if;
	import bcdcal_pkg::*;

	bcdcal_time_t count;
	bcdcal_time_t alarm;
	logic [6:0]   cmp_en;
	logic         match;

	modport regs (output count, output alarm, output cmp_en, input match);
	modport cmp  (input count, input alarm, input cmp_en, output match);

endinterface : bcdcal_cmp_if
`default_nettype wire

// ---- hw/bcdcal_alarm.sv ----
// alarm comparator: running count against the enabled alarm fields
`timescale 1ns/10ps
`default_nettype none
module bcdcal_alarm (
	bcdcal_cmp_if.cmp cmp
);
	import bcdcal_pkg::*;

	logic [6:0] field_eq;

	// ----------------------------------------------------------------
	// per-field equality, same order as the compare-enable bits
	// ----------------------------------------------------------------
	assign field_eq[0] = (cmp.count.sec  == cmp.alarm.sec);
	assign field_eq[1] = (cmp.count.min  == cmp.alarm.min);
	assign field_eq[2] = (cmp.count.hr   == cmp.alarm.hr);
	assign field_eq[3] = (cmp.count.dow  == cmp.alarm.dow);
	assign field_eq[4] = (cmp.count.date == cmp.alarm.date);
	assign field_eq[5] = (cmp.count.mon  == cmp.alarm.mon);
	assign field_eq[6] = (cmp.count.year == cmp.alarm.year);

	// (R15) masked field compare
	// with no field enabled there is nothing to match, so no alarm
	assign cmp.match = (|cmp.cmp_en) & (&(field_eq | ~cmp.cmp_en));

endmodule : bcdcal_alarm
`default_nettype wire

// ---- tb/bcdcal_host.sv ----
// host side model: register port master and interrupt acknowledge
`timescale 1ns/10ps
`default_nettype none
module bcdcal_host (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       irq_out_n,
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	output logic            reg_rd,
	output logic            irq_clear
);
	logic ack_en;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		irq_clear = 1'b0;
		ack_en = 1'b0;
	end

	// acknowledge only when the bench allows it, so a held pin can be seen
	always @(posedge clk_sys) begin
		irq_clear <= ack_en && !irq_out_n && !irq_clear;
	end

	// released lines show inverted data so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : bcdcal_host
`default_nettype wire

// ---- tb/bcdcal_top_properties.sv ----
// concurrent checks on the calendar clock top ports
`timescale 1ns/10ps
`default_nettype none
module bcdcal_top_chk (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic [7:0]              reg_addr,
	input wire logic                    reg_wr,
	input wire logic [7:0]              reg_wdata,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_rdata,
	input wire bcdcal_pkg::bcdcal_pwr_t pwr_state,
	input wire logic                    irq_clear,
	input wire logic                    irq_out_n,
	input wire logic                    alarm_int_set,
	input wire logic                    wake_req
);
	import bcdcal_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----
	// shadow of the control register
	// ----
	logic [2:0] ctl_r;
	logic [2:0] ctl_nxt;
	always_comb begin
		ctl_nxt = ctl_r;
		if (reg_wr && reg_addr == 8'h3a)
			ctl_nxt = reg_wdata[2:0];
	end
	always_ff @(posedge clk_sys) begin
		if (rst)
			ctl_r <= 3'h0;
		else
			ctl_r <= ctl_nxt;
	end
	sequence s_occ_wr;
		reg_wr && reg_addr == 8'h49 && !ctl_r[2];
	endsequence
	sequence s_occ_rd;
		reg_rd && !reg_wr && reg_addr == 8'h49 && !ctl_r[2];
	endsequence
	chk_int_unmask:
		assert property (alarm_int_set |-> $past(ctl_r[1]))
		else $error("alarm flag while masked");
	chk_event_enable:
		assert property ((alarm_int_set || wake_req) |-> $past(ctl_r[2]))
		else $error("alarm event while disabled");
	chk_irq_cause:
		assert property ($fell(irq_out_n) |-> alarm_int_set && !$past(pwr_state[1]))
		else $error("interrupt without alarm");
	chk_irq_hold:
		assert property (!irq_out_n && !irq_clear |=> !irq_out_n)
		else $error("interrupt dropped early");
	chk_irq_release:
		assert property (!irq_out_n && irq_clear && !ctl_r[2] |=> irq_out_n)
		else $error("interrupt not released");
	chk_wake_off:
		assert property (wake_req |-> $past(pwr_state[1]))
		else $error("wake outside off state");
	chk_int_pulse:
		assert property (alarm_int_set |=> !alarm_int_set)
		else $error("alarm flag pulse too long");
	chk_int_pin:
		assert property (alarm_int_set && !$past(pwr_state[1]) |-> !irq_out_n)
		else $error("alarm flag without pin");
	chk_occ_clear:
		assert property (s_occ_wr ##1 !reg_wr ##1 s_occ_rd |=> !reg_rdata[7])
		else $error("occurred bit not cleared");
endmodule : bcdcal_top_chk
bind bcdcal_top bcdcal_top_chk bcdcal_top_chk_i (.clk_sys(clk_sys),
	.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_state(pwr_state),
	.irq_clear(irq_clear), .irq_out_n(irq_out_n),
	.alarm_int_set(alarm_int_set), .wake_req(wake_req));
`default_nettype wire

// ---- tb/tb_bcd_calendar_clock_alarm.sv ----
// self-checking bench for the calendar clock top
`timescale 1ns/10ps
`default_nettype none
module tb_bcd_calendar_clock_alarm;
	import bcdcal_pkg::*;
	// ----
	// short timebase keeps each tick four cycles
	// ----
	localparam int TICK = 4;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	bcdcal_pwr_t pwr_state = BCDCAL_PWR_ON;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, irq_clear, irq_out_n;
	logic        alarm_int_set, wake_req;
	int          miscompares = 0;
	int          num_checks = 0;
	int          n_int = 0;
	int          n_wake = 0;

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_int <= n_int + int'(alarm_int_set);
		n_wake <= n_wake + int'(wake_req);
		if (!rst && $isunknown({alarm_int_set, wake_req, irq_out_n})) begin
			miscompares++;
			$display("[ERR] %0t unknown event output", $time);
		end
	end

	bcdcal_top #(.TICK_CYCLES(TICK)) bcdcal_top_i (.clk_sys(clk_sys),
		.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pwr_state(pwr_state), .irq_clear(irq_clear), .irq_out_n(irq_out_n),
		.alarm_int_set(alarm_int_set), .wake_req(wake_req));
	bcdcal_host host_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
		.irq_out_n(irq_out_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .irq_clear(irq_clear));

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp_cnt(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			miscompares++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : cmp_cnt
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_i.rd(a, d);
		cmp8(d, exp);
	endtask : rdc
	// time packed as year,mon,date,dow,hr,min,sec; run stopped first
	task automatic set_time(input logic [55:0] t);
		host_i.wr(8'h3a, 8'h00);
		for (int i = 0; i < 7; i++)
			host_i.wr(8'h3b + 8'(i), t[8*i+:8]);
	endtask : set_time
	// stop lands between the first and second tick
	task automatic tick(input logic [7:0] c);
		host_i.wr(8'h3a, c);
		repeat (TICK) @(posedge clk_sys);
		host_i.wr(8'h3a, c & 8'hfe);
	endtask : tick
	task automatic roll(input logic [55:0] t, input logic [55:0] e);
		set_time(t);
		tick(8'h01);
		for (int i = 0; i < 7; i++)
			rdc(8'h3b + 8'(i), e[8*i+:8]);
	endtask : roll
	task automatic alarm(input logic [7:0] c, input bcdcal_pwr_t p,
		input int e_int, input int e_wake, input logic [7:0] occ);
		int i0;
		int w0;
		@(posedge clk_sys);
		pwr_state <= p;
		set_time(56'h21_04_30_02_12_00_04);
		host_i.wr(8'h42, 8'h05);
		host_i.wr(8'h43, 8'h33);
		host_i.wr(8'h49, 8'h01);
		i0 = n_int;
		w0 = n_wake;
		tick(c);
		repeat (3) @(posedge clk_sys);
		cmp_cnt(n_int - i0, e_int);
		cmp_cnt(n_wake - w0, e_wake);
		rdc(8'h49, occ);
	endtask : alarm

	task automatic t_reset;
		for (int a = 8'h3a; a <= 8'h4b; a++)
			rdc(8'(a), 8'h00);
		cmp8({7'h00, irq_out_n}, 8'h01);
	endtask : t_reset
	task automatic t_hold;
		host_i.wr(8'h3b, 8'h12);
		repeat (3 * TICK) @(posedge clk_sys);
		rdc(8'h3b, 8'h12);
		host_i.wr(8'h4a, 8'h5a);
		rdc(8'h4a, 8'h00);
	endtask : t_hold
	task automatic t_rollover;
		roll(56'h99_12_31_07_23_59_59, 56'h00_01_01_01_00_00_00);
		roll(56'h00_02_28_03_23_59_59, 56'h00_02_29_04_00_00_00);
		roll(56'h05_02_28_03_23_59_59, 56'h05_03_01_04_00_00_00);
		roll(56'h21_04_30_06_23_59_59, 56'h21_05_01_07_00_00_00);
		roll(56'h21_04_30_02_12_34_58, 56'h21_04_30_02_12_34_59);
	endtask : t_rollover
	task automatic t_alarm_on;
		alarm(8'h07, BCDCAL_PWR_ON, 1, 0, 8'h81);
		cmp8({7'h00, irq_out_n}, 8'h00);
		host_i.wr(8'h3a, 8'h00);
		host_i.ack_en <= 1'b1;
		repeat (4) @(posedge clk_sys);
		host_i.ack_en <= 1'b0;
		cmp8({7'h00, irq_out_n}, 8'h01);
		host_i.wr(8'h49, 8'h01);
		rdc(8'h49, 8'h01);
	endtask : t_alarm_on
	task automatic t_alarm_masked;
		alarm(8'h05, BCDCAL_PWR_SLEEP, 0, 0, 8'h81);
		cmp8({7'h00, irq_out_n}, 8'h01);
	endtask : t_alarm_masked
	task automatic t_alarm_off;
		alarm(8'h05, BCDCAL_PWR_OFF, 0, 1, 8'h81);
		cmp8({7'h00, irq_out_n}, 8'h01);
	endtask : t_alarm_off
	task automatic t_alarm_dis;
		alarm(8'h03, BCDCAL_PWR_ON, 0, 0, 8'h01);
	endtask : t_alarm_dis

	task automatic end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial begin
		#40us;
		miscompares++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_hold;
		t_rollover;
		t_alarm_on;
		t_alarm_masked;
		t_alarm_off;
		t_alarm_dis;
		end_sim;
	end
endmodule : tb_bcd_calendar_clock_alarm
`default_nettype wire
